/* File: core/ssc_pkg.sv */
// constants shared by the step sequencer files
package ssc_pkg;
    // ********************************************************
    // step table geometry
    // ********************************************************
    localparam int STEP_COUNT = 16;
    localparam int STEP_W = 4;
    localparam int CODE_W = 4;
    localparam int PHASE_W = 8;
    localparam int DUR_W = 32;
    localparam int JCNT_W = 16;
    // ********************************************************
    // register byte offsets
    // ********************************************************
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_STEP_BASE = 12'h100;
    localparam logic [1:0] WORD_DURATION = 2'h0;
    localparam logic [1:0] WORD_CONFIG = 2'h1;
    localparam logic [1:0] WORD_JUMPS = 2'h2;
    // ********************************************************
    // control register fields
    // ********************************************************
    localparam int CTL_EXT_PIN_EN = 0;
    localparam int CTL_SUB_ROUTE = 1;
    localparam int CTL_CMD_START = 2;
    localparam int CTL_CMD_STOP = 3;
    localparam int CTL_CMD_HOLD = 4;
    localparam int CTL_CMD_RESUME = 5;
    localparam int CTL_CMD_EDGE = 6;
    // ********************************************************
    // step config word fields
    // ********************************************************
    localparam int CFG_PAUSE = 0;
    localparam int CFG_ALIGN = 1;
    localparam int CFG_JUMP = 2;
    localparam int CFG_JUMP_INF = 3;
    localparam int CFG_LEVEL = 4;
    localparam int CFG_EDGE = 5;
    localparam int CFG_END = 6;
    localparam int CFG_CODE_LSB = 8;
    localparam int CFG_TGT_LSB = 12;
    localparam int CFG_LVL_LSB = 16;
    localparam int CFG_EDG_LSB = 20;
    localparam int CFG_PH_LSB = 24;
    // options that step zero never honours
    localparam logic [31:0] CFG_STEP0_MASK = 32'h00FF_F07D;
    // ********************************************************
    // external input indices and reset values
    // ********************************************************
    localparam int IN_START = 0;
    localparam int IN_STOP = 1;
    localparam int IN_HOLD = 2;
    localparam int IN_EDGE = 3;
    localparam int IN_LEVEL = 4;
    localparam int IN_COUNT = 5;
    localparam logic [IN_COUNT-1:0] IN_IDLE_LVL = 5'h1F;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_ARMED, ST_RUN, ST_HOLD} ssc_state_e;
endpackage

/* File: core/ssc_pin_if.sv */
// carries raw control pins and their synchronised edges
`timescale 1ns/1ps
interface ssc_pin_if;
    import ssc_pkg::*;
    logic [IN_COUNT-1:0] raw;
    logic [IN_COUNT-1:0] level;
    logic [IN_COUNT-1:0] fall;
    logic [IN_COUNT-1:0] rise;
    modport syncer (input raw, output level, fall, rise);
    modport core (output raw, input level, fall, rise);
endinterface

/* File: core/ssc_input_sync.sv */
// two-stage synchronisers and edge detectors for control pins
`timescale 1ns/1ps
module ssc_input_sync (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // pins
    ssc_pin_if.syncer pins
);
    import ssc_pkg::*;
    genvar g;
    generate
        for (g = 0; g < IN_COUNT; g++) begin : g_pin
            logic meta;
            logic stable;
            logic prev;
            // meta feeds only the second stage
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    meta <= IN_IDLE_LVL[g];
                    stable <= IN_IDLE_LVL[g];
                    prev <= IN_IDLE_LVL[g];
                end else begin
                    meta <= pins.raw[g];
                    stable <= meta;
                    prev <= stable;
                end
            end
            assign pins.level[g] = stable;
            assign pins.fall[g] = prev & ~stable;
            assign pins.rise[g] = ~prev & stable;
        end
    endgenerate
endmodule

/* File: core/ssc_top.sv */
// step sequencer core with AXI4-Lite register access
`timescale 1ns/1ps
// Function
// - step lasts its programmed duration first
// - pause option holds after duration until resume
// - step zero ignores advanced step options except align
// - align end to programmed reference phase
// - jump target replaces next numbered step
// - N jumps, step runs N plus one
// - infinite count jumps until stopped
// - active level branch goes to destination
// - level sampled after duration, hold excluded
// - panel or pin edge branches to destination
// - finish continue advances, end returns idle
// - drive step sync nibble, D3 is MSB
// - optionally route D0 to sub output
// - falling start accepted only when armed
// - falling stop ends sequence at step 0
// - hold falling pauses, rising resumes
// - level branch input active low
module ssc_top (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // axi4-lite slave
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // waveform phase and external control pins
    input wire logic [ssc_pkg::PHASE_W-1:0] i_phase,
    input wire logic i_ext_start_n,
    input wire logic i_ext_stop_n,
    input wire logic i_ext_hold,
    input wire logic i_ext_edge_n,
    input wire logic i_ext_level_n,
    // connector outputs
    output logic [ssc_pkg::CODE_W-1:0] o_sync_code,
    output logic o_sub_out,
    output logic o_running
);
    import ssc_pkg::*;

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // true when addr lands inside the step table
    function automatic logic is_step(input logic [11:0] a);
        return (a[11:8] == OFF_STEP_BASE[11:8]) && (a[3:2] != 2'h3);
    endfunction

    // ********************************************************
    // pin synchronisation
    // ********************************************************
    ssc_pin_if pins ();
    assign pins.raw = {i_ext_level_n, i_ext_edge_n, i_ext_hold,
                       i_ext_stop_n, i_ext_start_n};
    ssc_input_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .pins(pins)
    );

    // ********************************************************
    // registers
    // ********************************************************
    logic [31:0] step_dur [STEP_COUNT];
    logic [31:0] step_cfg [STEP_COUNT];
    logic [JCNT_W-1:0] step_jmp [STEP_COUNT];
    logic [JCNT_W-1:0] jmp_left [STEP_COUNT];
    logic ext_en;
    logic sub_route;
    logic [6:0] cmd;
    ssc_state_e state;
    logic [STEP_W-1:0] step;
    logic [DUR_W-1:0] timer;
    logic paused_done;
    logic edge_seen;

    // axi write side
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    assign do_write = aw_held && w_held && !o_bvalid;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= RST_WORD;
            w_strb <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= AXI_OKAY;
        end else begin
            o_awready <= !aw_held && !o_awready;
            o_wready <= !w_held && !o_wready;
            if (i_awvalid && o_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_addr == OFF_CONTROL || is_step(aw_addr))
                           ? AXI_OKAY : AXI_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // control word and one-cycle command strobes
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_en <= 1'b0;
            sub_route <= 1'b0;
            cmd <= 7'h00;
        end else begin
            cmd <= 7'h00;
            if (do_write && aw_addr == OFF_CONTROL && w_strb[0]) begin
                ext_en <= w_data[CTL_EXT_PIN_EN];
                sub_route <= w_data[CTL_SUB_ROUTE];
                cmd <= w_data[6:0];
            end
        end
    end

    // step table storage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int s = 0; s < STEP_COUNT; s++) begin
                step_dur[s] <= RST_WORD;
                step_cfg[s] <= RST_WORD;
                step_jmp[s] <= JCNT_W'(0);
            end
        end else if (do_write && is_step(aw_addr)) begin
            case (aw_addr[3:2])
                WORD_DURATION: step_dur[aw_addr[7:4]] <=
                    merge(step_dur[aw_addr[7:4]], w_data, w_strb);
                WORD_CONFIG: step_cfg[aw_addr[7:4]] <=
                    merge(step_cfg[aw_addr[7:4]], w_data, w_strb);
                WORD_JUMPS: step_jmp[aw_addr[7:4]] <= JCNT_W'(merge(
                    {16'h0000, step_jmp[aw_addr[7:4]]}, w_data, w_strb));
                default: ;
            endcase
        end
    end

    // axi read side
    logic [31:0] rd_word;
    always_comb begin
        rd_word = RST_WORD;
        if (i_araddr == OFF_CONTROL) begin
            rd_word = {30'h0, sub_route, ext_en};
        end else if (i_araddr == OFF_STATUS) begin
            rd_word = {24'h0, step, 2'h0, state};
        end else if (is_step(i_araddr)) begin
            case (i_araddr[3:2])
                WORD_DURATION: rd_word = step_dur[i_araddr[7:4]];
                WORD_CONFIG: rd_word = step_cfg[i_araddr[7:4]];
                default: rd_word = {16'h0000, step_jmp[i_araddr[7:4]]};
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= RST_WORD;
            o_rresp <= AXI_OKAY;
        end else begin
            o_arready <= !o_rvalid && !o_arready;
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= (i_araddr == OFF_CONTROL ||
                            i_araddr == OFF_STATUS || is_step(i_araddr))
                           ? AXI_OKAY : AXI_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ********************************************************
    // sequencer decisions
    // ********************************************************
    logic [31:0] cfg;
    assign cfg = (step == '0) ? (step_cfg[0] & ~CFG_STEP0_MASK)
                              : step_cfg[step];

    logic elapsed, phase_ok, step_end, auto_pause, lvl_hit;
    logic edge_now, go_start, go_stop, go_hold, go_resume, jump_take;
    assign elapsed = timer >= step_dur[step];
    assign phase_ok = !cfg[CFG_ALIGN] ||
        i_phase == cfg[CFG_PH_LSB +: PHASE_W];
    assign auto_pause = cfg[CFG_PAUSE] && !paused_done;
    assign step_end = state == ST_RUN && elapsed && !auto_pause &&
                      phase_ok;
    // level input is active low and only looked at here
    assign lvl_hit = cfg[CFG_LEVEL] && !pins.level[IN_LEVEL];
    assign edge_now = cfg[CFG_EDGE] && (edge_seen || cmd[CTL_CMD_EDGE]
                      || (ext_en && pins.fall[IN_EDGE]));
    assign go_start = cmd[CTL_CMD_START] ||
                      (ext_en && pins.fall[IN_START]);
    assign go_stop = cmd[CTL_CMD_STOP] || (ext_en && pins.fall[IN_STOP]);
    assign go_hold = cmd[CTL_CMD_HOLD] || (ext_en && pins.fall[IN_HOLD]);
    assign go_resume = cmd[CTL_CMD_RESUME] ||
                       (ext_en && pins.rise[IN_HOLD]);
    assign jump_take = cfg[CFG_JUMP] &&
        (cfg[CFG_JUMP_INF] || jmp_left[step] != '0);

    // ********************************************************
    // state machine
    // ********************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= ST_ARMED;
            step <= '0;
            timer <= '0;
            paused_done <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            case (state)
                ST_ARMED: begin
                    if (go_start) begin
                        state <= ST_RUN;
                        step <= '0;
                        timer <= '0;
                        paused_done <= 1'b0;
                    end
                end
                ST_RUN, ST_HOLD: begin
                    // latch an edge that lands while holding
                    if (edge_now) begin
                        edge_seen <= 1'b1;
                    end
                    if (go_stop) begin
                        state <= ST_ARMED;
                        step <= '0;
                        edge_seen <= 1'b0;
                    end else if (state == ST_HOLD) begin
                        if (go_resume) begin
                            state <= ST_RUN;
                        end
                    end else if (go_hold) begin
                        state <= ST_HOLD;
                    end else if (edge_now) begin
                        step <= cfg[CFG_EDG_LSB +: STEP_W];
                        timer <= '0;
                        paused_done <= 1'b0;
                        edge_seen <= 1'b0;
                    end else if (!elapsed) begin
                        // timer frozen while holding
                        timer <= timer + 1'b1;
                    end else if (auto_pause) begin
                        state <= ST_HOLD;
                        paused_done <= 1'b1;
                    end else if (step_end) begin
                        timer <= '0;
                        paused_done <= 1'b0;
                        if (lvl_hit) begin
                            step <= cfg[CFG_LVL_LSB +: STEP_W];
                        end else if (jump_take) begin
                            step <= cfg[CFG_TGT_LSB +: STEP_W];
                        end else if (cfg[CFG_END] ||
                                     step == STEP_W'(STEP_COUNT - 1)) begin
                            state <= ST_ARMED;
                            step <= '0;
                        end else begin
                            step <= step + 1'b1;
                        end
                    end
                end
                default: state <= ST_ARMED;
            endcase
        end
    end

    // jump budgets reload on every start
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int s = 0; s < STEP_COUNT; s++) begin
                jmp_left[s] <= JCNT_W'(0);
            end
        end else if (state == ST_ARMED && go_start) begin
            for (int s = 0; s < STEP_COUNT; s++) begin
                jmp_left[s] <= step_jmp[s];
            end
        end else if (step_end && !edge_now && !lvl_hit && jump_take &&
                     !cfg[CFG_JUMP_INF] && !go_stop && !go_hold) begin
            jmp_left[step] <= jmp_left[step] - 1'b1;
        end
    end

    // ********************************************************
    // connector outputs
    // ********************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_sync_code <= '0;
            o_sub_out <= 1'b0;
            o_running <= 1'b0;
        end else begin
            o_sync_code <= (state == ST_ARMED) ? '0
                           : cfg[CFG_CODE_LSB +: CODE_W];
            o_sub_out <= sub_route && state != ST_ARMED &&
                         cfg[CFG_CODE_LSB];
            o_running <= state == ST_RUN;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    sequence s_auto_hold;
        state == ST_RUN && elapsed && auto_pause && !go_stop &&
        !go_hold && !edge_now;
    endsequence
    sequence s_in_hold;
        state == ST_HOLD;
    endsequence
    property p_min_duration;
        @(posedge i_core_clk) disable iff (i_rst)
        state == ST_RUN && !elapsed && !go_stop && !go_hold && !edge_now
        |=> state == ST_RUN && $stable(step);
    endproperty
    a_min_duration: assert property (p_min_duration)
        else $error("step ended before its duration");
    property p_auto_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        s_auto_hold |=> s_in_hold ##0 paused_done;
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("pause option did not hold");
    property p_step0_plain;
        @(posedge i_core_clk) disable iff (i_rst)
        step == '0 && step_end && !go_stop && !go_hold
        |=> state == ST_RUN && step == STEP_W'(1);
    endproperty
    a_step0_plain: assert property (p_step0_plain)
        else $error("step zero honoured an option");
    property p_phase_end;
        @(posedge i_core_clk) disable iff (i_rst)
        state == ST_RUN && elapsed && !auto_pause && cfg[CFG_ALIGN] &&
        i_phase != cfg[CFG_PH_LSB +: PHASE_W] && !go_stop && !go_hold &&
        !edge_now |=> state == ST_RUN && $stable(step);
    endproperty
    a_phase_end: assert property (p_phase_end)
        else $error("step ended off reference phase");
    property p_jump;
        @(posedge i_core_clk) disable iff (i_rst)
        step_end && !go_stop && !go_hold && !edge_now && !lvl_hit &&
        jump_take |=> step == $past(cfg[CFG_TGT_LSB +: STEP_W]);
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target not taken");
    property p_level;
        @(posedge i_core_clk) disable iff (i_rst)
        step_end && !go_stop && !go_hold && !edge_now && lvl_hit
        |=> step == $past(cfg[CFG_LVL_LSB +: STEP_W]) && state == ST_RUN;
    endproperty
    a_level: assert property (p_level)
        else $error("level branch not taken");
    property p_stop;
        @(posedge i_core_clk) disable iff (i_rst)
        state != ST_ARMED && go_stop |=> state == ST_ARMED && step == '0;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end sequence");
    property p_hold_frozen;
        @(posedge i_core_clk) disable iff (i_rst)
        s_in_hold ##0 !go_stop ##0 !edge_now |=> $stable(timer);
    endproperty
    a_hold_frozen: assert property (p_hold_frozen)
        else $error("timer ran while holding");
    property p_code;
        @(posedge i_core_clk) disable iff (i_rst)
        state != ST_ARMED |=> o_sync_code ==
            $past(cfg[CFG_CODE_LSB +: CODE_W]);
    endproperty
    a_code: assert property (p_code)
        else $error("sync nibble mismatch");
endmodule

/* File: verification/ssc_pin_model.sv */
// external control pin source for the step sequencer
`timescale 1ns/1ps
// ****************************************
// control pin driver
// ****************************************
module ssc_pin_model
    import ssc_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // pins toward the sequencer
    output logic [ssc_pkg::IN_COUNT-1:0] o_pins
);
    initial o_pins = IN_IDLE_LVL;
    // level held long enough for the two-flop syncers to see it
    task automatic drive(input int idx, input logic v);
        @(posedge i_core_clk);
        o_pins[idx] <= v;
        repeat (6) @(posedge i_core_clk);
    endtask
endmodule

/* File: verification/test_step_sequencer_control.sv */
// self-checking bench for the step sequencer
`timescale 1ns/1ps
module test_step_sequencer_control;
    import ssc_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk, rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
    logic sub, run;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd, rdat;
    logic [1:0] rsp, brsp, rrsp;
    logic [PHASE_W-1:0] ph;
    logic [IN_COUNT-1:0] pins;
    logic [CODE_W-1:0] code, last;
    logic [CODE_W-1:0] seen[$];
    int failures, checks;
    ssc_pin_model i_pins (.i_core_clk(clk), .o_pins(pins));
    ssc_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_awaddr(awa),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
        .i_wvalid(wv), .o_wready(wr), .o_bresp(brsp), .o_bvalid(bv),
        .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
        .o_rdata(rdat), .o_rresp(rrsp), .o_rvalid(rv), .i_rready(rre),
        .i_phase(ph), .i_ext_start_n(pins[IN_START]),
        .i_ext_stop_n(pins[IN_STOP]), .i_ext_hold(pins[IN_HOLD]),
        .i_ext_edge_n(pins[IN_EDGE]), .i_ext_level_n(pins[IN_LEVEL]),
        .o_sync_code(code), .o_sub_out(sub), .o_running(run));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) ph <= ph + 1'b1;
    // record each change of the code nibble, which shows the step order
    always @(posedge clk) if (code !== last) begin
        seen.push_back(code);
        last = code;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, td;
        ta = 1'b0;
        td = 1'b0;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(posedge clk);
            ta = ta | awr;
            td = td | wr;
            if (ta) awv <= 1'b0;
            if (td) wv <= 1'b0;
        end while (!(ta && td));
        do @(posedge clk); while (!bv);
        bre <= 1'b0;
        rsp = brsp;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rre <= 1'b0;
        rd = rdat;
        rsp = rrsp;
    endtask
    task automatic step(input int s, input logic [31:0] c, j);
        axw(OFF_STEP_BASE + 12'(16 * s), 32'h6);
        axw(OFF_STEP_BASE + 12'(16 * s + 4), c);
        axw(OFF_STEP_BASE + 12'(16 * s + 8), j);
    endtask
    task automatic chk_log(input logic [31:0] e, input int n);
        while (seen.size() < n) @(posedge clk);
        for (int i = 0; i < n; i++)
            chk("code", 32'(seen[i]), (e >> (4 * (n - 1 - i))) & 32'hF);
        seen.delete();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs_jump();
        axr(OFF_CONTROL);
        chk("control", rd, RST_WORD);
        axr(12'h008);
        chk("unmapped", 32'(rsp), 32'(AXI_SLVERR));
        step(0, 32'h0000_0501, 0);
        step(1, 32'h0000_0A00, 0);
        step(2, 32'h0000_1C04, 1);
        step(3, 32'h8000_0342, 0);
        axw(OFF_CONTROL, 32'h4);
        chk("bresp", 32'(rsp), 32'(AXI_OKAY));
        chk_log(32'h05ACAC30, 7);
        $display("jump test done");
    endtask
    task automatic t_pins_pause();
        step(0, 32'h0000_0100, 0);
        step(1, 32'h0000_0201, 0);
        step(2, 32'h0004_0310, 0);
        step(3, 32'h0000_0540, 0);
        step(4, 32'h0000_0440, 0);
        axw(OFF_CONTROL, 32'h1);
        i_pins.drive(IN_LEVEL, 1'b0);
        i_pins.drive(IN_START, 1'b0);
        i_pins.drive(IN_START, 1'b1);
        while (seen.size() < 2) @(posedge clk);
        while (run) @(posedge clk);
        axr(OFF_STATUS);
        chk("status", rd & 32'hF3, 32'h12);
        i_pins.drive(IN_HOLD, 1'b0);
        i_pins.drive(IN_HOLD, 1'b1);
        chk_log(32'h12340, 5);
        i_pins.drive(IN_LEVEL, 1'b1);
        $display("pause test done");
    endtask
    task automatic t_edge_inf();
        step(1, 32'h0020_1E2C, 0);
        step(2, 32'h0000_0640, 0);
        axw(OFF_CONTROL, 32'h5);
        repeat (100) @(posedge clk);
        axr(OFF_STATUS);
        chk("inf", rd & 32'hF3, 32'h11);
        axw(OFF_CONTROL, 32'h11);
        axw(OFF_CONTROL, 32'h41);
        axr(OFF_STATUS);
        chk("hold", rd & 32'hF3, 32'h12);
        axw(OFF_CONTROL, 32'h21);
        chk_log(32'h1E60, 4);
        $display("edge test done");
    endtask
    task automatic t_stop();
        axw(OFF_STEP_BASE, 32'h400);
        axw(OFF_STEP_BASE + 12'h4, 32'h0000_0700);
        axw(OFF_CONTROL, 32'h3);
        i_pins.drive(IN_START, 1'b0);
        i_pins.drive(IN_START, 1'b1);
        chk("sub", 32'(sub), 32'h1);
        i_pins.drive(IN_STOP, 1'b0);
        chk("run", 32'(run), 32'h0);
        chk("code0", 32'(code), 32'h0);
        $display("stop test done");
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        rst = 1'b1; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0;
        rre = 1'b0; awa = 12'h0; ara = 12'h0; wd = 32'h0; ph = '0;
        last = '0; failures = 0; checks = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs_jump();
        t_pins_pause();
        t_edge_inf();
        t_stop();
        print_verdict();
    end
endmodule
